//--- pkg/dpio_pkg.sv
// Package for the dual-port I/O block: register map, fields, resets, types
package dpio_pkg;
  // Register byte offsets
  localparam logic [7:0] wide_pin_levels_off = 8'h00;
  localparam logic [7:0] wide_latch_off = 8'h04;
  localparam logic [7:0] wide_dir_off = 8'h08;
  localparam logic [7:0] ctrl_pin_levels_off = 8'h0C;
  localparam logic [7:0] ctrl_latch_off = 8'h10;
  localparam logic [7:0] ctrl_dir_off = 8'h14;
  localparam logic [7:0] pwm_config_off = 8'h18;
  localparam logic [7:0] analog_sel_off = 8'h1C;
  // Field positions in the control-port direction register
  localparam int slave_select_bit = 4;
  localparam int overrun_bit = 5;
  localparam int out_pending_bit = 6;
  localparam int in_pending_bit = 7;
  // Field positions in the pwm config register
  localparam int pwm_mode_lo_bit = 6;
  localparam int pwm_mode_hi_bit = 7;
  localparam int pwm_tristate_bit = 0;
  // Reset values and AXI response codes
  localparam logic [7:0] wide_dir_rst = 8'hFF;
  localparam logic [2:0] ctrl_dir_rst = 3'h7;
  localparam logic [2:0] analog_sel_rst = 3'h7;
  localparam logic [1:0] axi_resp_okay = 2'h0;
  localparam logic [1:0] axi_resp_slverr = 2'h2;

  typedef enum logic [2:0] {
    dpio_idle_s = 3'b001,
    dpio_wresp_s = 3'b010,
    dpio_rresp_s = 3'b100
  } dpio_bus_state_t;

  typedef struct packed {
    logic [7:0] wide_in;
    logic [2:0] ctrl_in;
  } dpio_pins_t;

  typedef struct packed {
    dpio_bus_state_t wst;
    dpio_bus_state_t rst;
    logic awtaken;
    logic wtaken;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] wide_latch;
    logic [7:0] wide_dir;
    logic [2:0] ctrl_latch;
    logic [2:0] ctrl_dir;
    logic slave_select;
    logic overrun;
    logic [7:0] pwm_config;
    logic [2:0] analog_sel;
    dpio_pins_t sync1;
    dpio_pins_t sync2;
    logic [7:0] wide_out;
    logic [7:0] wide_oe;
    logic [2:0] ctrl_out;
    logic [2:0] ctrl_oe;
  } dpio_state_t;
endpackage : dpio_pkg

//--- logic/dpio_top.sv
// Dual-port I/O block with slave-port and pwm override, AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Slave read drives latch, ignoring direction
// - Slave mode makes wide pins inputs
// - Pwm B, C, D outrank port and slave
// - Pwm pins optionally float during shutdown
// - Control port has three programmable pins
// - Analog control pins read as zero
// - Direction one floats pin, zero drives latch
// - Direction still governs drivers in analog
// - Power-on makes control pins analog
// - Upper direction bits hold slave controls
// - Control latch is directly addressable
// - Unimplemented bits read as zero
// - Registers absent on small package
// - Slave select bit switches wide port
// - Control pins are read, write, select strobes
// - Dual or quad pwm disables slave port
module dpio_top #(
  parameter bit large_package = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Wide-port pins, upper four
  input wire logic [7:4] wide_pin_in,
  output logic [7:4] wide_pin_out,
  output logic [7:4] wide_pin_oe,
  // Control-port pins
  input wire logic [2:0] ctrl_pin_in,
  output logic [2:0] ctrl_pin_out,
  output logic [2:0] ctrl_pin_oe,
  // Pwm channel drive and shutdown
  input wire logic pwm_channel_b_out,
  input wire logic pwm_channel_c_out,
  input wire logic pwm_channel_d_out,
  input wire logic pwm_shutdown,
  // Slave-port status from the slave handshake logic
  input wire logic input_word_pending,
  input wire logic output_word_pending,
  input wire logic input_overrun_set,
  // Slave-port enable toward the handshake logic
  output logic slave_interface_active
);

  dpio_pkg::dpio_state_t s_reg;
  dpio_pkg::dpio_state_t s_next;

  logic slave_on;
  logic pwm_on;
  logic slave_read;
  logic [7:0] wide_in_view;
  logic [2:0] ctrl_in_view;
  logic [2:0] pwm_drive;
  logic [7:0] wide_levels;

  // Byte lane merge for an 8-bit register
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] st);
    lane0 = st[0] ? d[7:0] : old;
  endfunction : lane0

  function automatic logic decode_ok(input logic [7:0] a);
    decode_ok = large_package && (a[1:0] == 2'h0) &&
      (a <= dpio_pkg::analog_sel_off);
  endfunction : decode_ok

  // Dual or quad pwm owns pins 5..7 and gates slave mode off
  assign pwm_on = s_reg.pwm_config[dpio_pkg::pwm_mode_hi_bit] |
    s_reg.pwm_config[dpio_pkg::pwm_mode_lo_bit];
  assign slave_on = s_reg.slave_select && !pwm_on;
  // Active-low strobes: select is pin 2, read is pin 0
  assign slave_read = slave_on && !s_reg.sync2.ctrl_in[2] &&
    !s_reg.sync2.ctrl_in[0];
  assign wide_in_view = s_reg.sync2.wide_in;
  assign ctrl_in_view = s_reg.sync2.ctrl_in & ~s_reg.analog_sel;
  assign pwm_drive = {pwm_channel_d_out, pwm_channel_c_out,
                      pwm_channel_b_out};
  assign wide_levels = {wide_in_view[7:4], 4'h0};

  always_comb begin
    s_next = s_reg;
    s_next.sync1.wide_in = {wide_pin_in, 4'h0};
    s_next.sync1.ctrl_in = ctrl_pin_in;
    s_next.sync2 = s_reg.sync1;
    // Overrun flag: set wins over software clear
    if (input_overrun_set) begin
      s_next.overrun = 1'b1;
    end

    // Write channel
    case (s_reg.wst)
      dpio_pkg::dpio_idle_s: begin
        if (s_axi_awvalid && !s_reg.awtaken) begin
          s_next.awtaken = 1'b1;
          s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.wtaken) begin
          s_next.wtaken = 1'b1;
          s_next.wdata = s_axi_wdata;
          s_next.wstrb = s_axi_wstrb;
        end
        if (s_reg.awtaken && s_reg.wtaken) begin
          s_next.awtaken = 1'b0;
          s_next.wtaken = 1'b0;
          s_next.wst = dpio_pkg::dpio_wresp_s;
          s_next.bresp = dpio_pkg::axi_resp_okay;
          if (!decode_ok(s_reg.awaddr)) begin
            s_next.bresp = dpio_pkg::axi_resp_slverr;
          end else begin
            case (s_reg.awaddr)
              dpio_pkg::wide_pin_levels_off,
              dpio_pkg::wide_latch_off: begin
                s_next.wide_latch = lane0(s_reg.wide_latch,
                  s_reg.wdata, s_reg.wstrb);
              end
              dpio_pkg::wide_dir_off: begin
                s_next.wide_dir = lane0(s_reg.wide_dir,
                  s_reg.wdata, s_reg.wstrb);
              end
              dpio_pkg::ctrl_pin_levels_off,
              dpio_pkg::ctrl_latch_off: begin
                if (s_reg.wstrb[0]) begin
                  s_next.ctrl_latch = s_reg.wdata[2:0];
                end
              end
              dpio_pkg::ctrl_dir_off: begin
                if (s_reg.wstrb[0]) begin
                  s_next.ctrl_dir = s_reg.wdata[2:0];
                  s_next.slave_select =
                    s_reg.wdata[dpio_pkg::slave_select_bit];
                  if (!s_reg.wdata[dpio_pkg::overrun_bit] &&
                      !input_overrun_set) begin
                    s_next.overrun = 1'b0;
                  end
                end
              end
              dpio_pkg::pwm_config_off: begin
                s_next.pwm_config = lane0(s_reg.pwm_config,
                  s_reg.wdata, s_reg.wstrb);
              end
              dpio_pkg::analog_sel_off: begin
                if (s_reg.wstrb[0]) begin
                  s_next.analog_sel = s_reg.wdata[2:0];
                end
              end
              default: begin
                s_next.bresp = dpio_pkg::axi_resp_slverr;
              end
            endcase
          end
        end
      end
      dpio_pkg::dpio_wresp_s: begin
        if (s_axi_bready) begin
          s_next.wst = dpio_pkg::dpio_idle_s;
        end
      end
      default: begin
        s_next.wst = dpio_pkg::dpio_idle_s;
      end
    endcase

    // Read channel
    case (s_reg.rst)
      dpio_pkg::dpio_idle_s: begin
        if (s_axi_arvalid) begin
          s_next.rst = dpio_pkg::dpio_rresp_s;
          s_next.rdata = 32'h0000_0000;
          s_next.rresp = dpio_pkg::axi_resp_okay;
          if (!decode_ok(s_axi_araddr)) begin
            s_next.rresp = dpio_pkg::axi_resp_slverr;
          end else begin
            case (s_axi_araddr)
              dpio_pkg::wide_pin_levels_off: begin
                s_next.rdata[7:0] = wide_levels;
              end
              dpio_pkg::wide_latch_off: begin
                s_next.rdata[7:0] = s_reg.wide_latch;
              end
              dpio_pkg::wide_dir_off: begin
                s_next.rdata[7:0] = s_reg.wide_dir;
              end
              dpio_pkg::ctrl_pin_levels_off: begin
                s_next.rdata[2:0] = ctrl_in_view;
              end
              dpio_pkg::ctrl_latch_off: begin
                s_next.rdata[2:0] = s_reg.ctrl_latch;
              end
              dpio_pkg::ctrl_dir_off: begin
                s_next.rdata[2:0] = s_reg.ctrl_dir;
                s_next.rdata[dpio_pkg::slave_select_bit] =
                  s_reg.slave_select;
                s_next.rdata[dpio_pkg::overrun_bit] = s_reg.overrun;
                s_next.rdata[dpio_pkg::out_pending_bit] =
                  output_word_pending;
                s_next.rdata[dpio_pkg::in_pending_bit] =
                  input_word_pending;
              end
              dpio_pkg::pwm_config_off: begin
                s_next.rdata[7:0] = s_reg.pwm_config;
              end
              dpio_pkg::analog_sel_off: begin
                s_next.rdata[2:0] = s_reg.analog_sel;
              end
              default: begin
                s_next.rresp = dpio_pkg::axi_resp_slverr;
              end
            endcase
          end
        end
      end
      dpio_pkg::dpio_rresp_s: begin
        if (s_axi_rready) begin
          s_next.rst = dpio_pkg::dpio_idle_s;
        end
      end
      default: begin
        s_next.rst = dpio_pkg::dpio_idle_s;
      end
    endcase

    // Wide-port pin drive, priority pwm over slave over port
    for (int i = 4; i < 8; i++) begin
      s_next.wide_out[i] = s_reg.wide_latch[i];
      s_next.wide_oe[i] = !s_reg.wide_dir[i];
      if (slave_on) begin
        s_next.wide_oe[i] = slave_read;
      end
      if (i >= 5 && pwm_on && !s_reg.wide_dir[i]) begin
        s_next.wide_out[i] = pwm_drive[i-5];
        s_next.wide_oe[i] = !(pwm_shutdown &&
          s_reg.pwm_config[dpio_pkg::pwm_tristate_bit]);
      end
    end
    s_next.wide_out[3:0] = 4'h0;
    s_next.wide_oe[3:0] = 4'h0;
    // Control-port drive: direction rules even in analog mode
    s_next.ctrl_out = s_reg.ctrl_latch;
    s_next.ctrl_oe = ~s_reg.ctrl_dir;
    if (slave_on) begin
      s_next.ctrl_oe = 3'h0;
    end
    if (!large_package) begin
      s_next.wide_oe = 8'h00;
      s_next.ctrl_oe = 3'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.wst <= dpio_pkg::dpio_idle_s;
      s_reg.rst <= dpio_pkg::dpio_idle_s;
      s_reg.wide_dir <= dpio_pkg::wide_dir_rst;
      s_reg.ctrl_dir <= dpio_pkg::ctrl_dir_rst;
      s_reg.analog_sel <= dpio_pkg::analog_sel_rst;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = (s_reg.wst == dpio_pkg::dpio_idle_s) &&
    !s_reg.awtaken;
  assign s_axi_wready = (s_reg.wst == dpio_pkg::dpio_idle_s) &&
    !s_reg.wtaken;
  assign s_axi_bvalid = s_reg.wst == dpio_pkg::dpio_wresp_s;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.rst == dpio_pkg::dpio_idle_s;
  assign s_axi_rvalid = s_reg.rst == dpio_pkg::dpio_rresp_s;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign wide_pin_out = s_reg.wide_out[7:4];
  assign wide_pin_oe = s_reg.wide_oe[7:4];
  assign ctrl_pin_out = s_reg.ctrl_out;
  assign ctrl_pin_oe = s_reg.ctrl_oe;
  assign slave_interface_active = slave_on;

endmodule : dpio_top

`default_nettype wire

//--- testbench/dpio_asserts.sv
// Bus and pin-drive assertions for the dual-port I/O block
`timescale 1ns/100ps
`default_nettype none
module dpio_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin drive
  input wire logic [7:4] wide_pin_oe,
  input wire logic [2:0] ctrl_pin_oe,
  input wire logic slave_interface_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_pins_off: assert property (disable iff (1'b0)
    !aresetn |=> wide_pin_oe == 4'h0 && ctrl_pin_oe == 3'h0)
    else $error("pin drivers on after reset");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_error_zero: assert property (
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returned data");
  a_slave_ctrl_off: assert property (
    slave_interface_active && $past(slave_interface_active) |->
    ctrl_pin_oe == 3'h0)
    else $error("control driver on in slave mode");
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_error: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_slave_drive: cover property (slave_interface_active && wide_pin_oe != 0);
endmodule : dpio_asserts

bind dpio_top dpio_asserts chk_u (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .wide_pin_oe, .ctrl_pin_oe, .slave_interface_active);
`default_nettype wire

//--- testbench/dpio_host_model.sv
// Far-side model: external host drive and pin level resolution
`timescale 1ns/100ps
`default_nettype none
module dpio_host_model (
  // Clock
  input wire logic aclk,
  // Device drive
  input wire logic [7:4] wide_pin_out,
  input wire logic [7:4] wide_pin_oe,
  input wire logic [2:0] ctrl_pin_out,
  input wire logic [2:0] ctrl_pin_oe,
  // Host drive
  input wire logic [7:4] host_wide,
  input wire logic host_wide_en,
  input wire logic [2:0] host_ctrl,
  input wire logic host_ctrl_en,
  // Resolved levels
  output logic [7:4] wide_pin_in,
  output logic [2:0] ctrl_pin_in
);
  logic [3:0] flt = 4'h5;
  // Undriven pins wander each cycle
  always @(posedge aclk) flt <= ~flt;
  // Host data and strobes where the device is not driving
  assign wide_pin_in = (wide_pin_oe & wide_pin_out) |
    (~wide_pin_oe & (host_wide_en ? host_wide : flt));
  assign ctrl_pin_in = (ctrl_pin_oe & ctrl_pin_out) |
    (~ctrl_pin_oe & (host_ctrl_en ? host_ctrl : flt[2:0]));
endmodule : dpio_host_model
`default_nettype wire

//--- testbench/dual_port_io_with_slave_override_tb_top.sv
// Register and pin tests for the dual-port I/O block
`timescale 1ns/100ps
`default_nettype none
module dual_port_io_with_slave_override_tb_top;
  localparam logic [1:0] ok = dpio_pkg::axi_resp_okay;
  localparam logic [1:0] er = dpio_pkg::axi_resp_slverr;
  localparam logic [31:0] z = 32'h0000_0000;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, pwm_shutdown;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, host_wide;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:4] wide_pin_in, wide_pin_out, wide_pin_oe;
  logic [2:0] ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe, host_ctrl;
  logic pwm_channel_b_out, pwm_channel_c_out, pwm_channel_d_out;
  logic input_word_pending, output_word_pending, input_overrun_set;
  logic slave_interface_active, host_wide_en, host_ctrl_en;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  dpio_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wide_pin_in, .wide_pin_out, .wide_pin_oe, .ctrl_pin_in, .ctrl_pin_out,
    .ctrl_pin_oe, .pwm_channel_b_out, .pwm_channel_c_out, .pwm_channel_d_out,
    .pwm_shutdown, .input_word_pending, .output_word_pending,
    .input_overrun_set, .slave_interface_active);
  dpio_host_model host_u (.aclk, .wide_pin_out, .wide_pin_oe, .ctrl_pin_out,
    .ctrl_pin_oe, .host_wide, .host_wide_en, .host_ctrl, .host_ctrl_en,
    .wide_pin_in, .ctrl_pin_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ha, hw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    @(negedge aclk);
    while (s_axi_awvalid || s_axi_wvalid) begin
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      @(negedge aclk);
    end
    while (!s_axi_bvalid) @(negedge aclk);
    chk(32'(s_axi_bresp), 32'(r));
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(r));
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic settle;
    repeat (4) @(negedge aclk);
  endtask : settle
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, pwm_shutdown, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {pwm_channel_b_out, pwm_channel_c_out, pwm_channel_d_out} = 3'h0;
    {input_word_pending, output_word_pending, input_overrun_set} = 3'h0;
    s_axi_wstrb = 4'h1;
    {host_wide, host_wide_en, host_ctrl, host_ctrl_en} = {4'h3, 1'b1, 3'h7, 1'b1};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(dpio_pkg::wide_dir_off, 32'h0000_00FF, ok);
    rd(dpio_pkg::wide_pin_levels_off, 32'h0000_0030, ok);
    rd(dpio_pkg::ctrl_dir_off, 32'h0000_0007, ok);
    rd(dpio_pkg::analog_sel_off, 32'h0000_0007, ok);
    host_ctrl <= 3'h5;
    rd(dpio_pkg::ctrl_pin_levels_off, z, ok);
    wr(dpio_pkg::analog_sel_off, z, ok);
    rd(dpio_pkg::ctrl_pin_levels_off, 32'h0000_0005, ok);
    host_ctrl_en <= 1'b0;
    wr(dpio_pkg::ctrl_latch_off, 32'h0000_0006, ok);
    wr(dpio_pkg::analog_sel_off, 32'h0000_0007, ok);
    wr(dpio_pkg::ctrl_dir_off, z, ok);
    settle;
    chk(32'(ctrl_pin_oe), 32'h0000_0007);
    chk(32'(ctrl_pin_out), 32'h0000_0006);
    rd(dpio_pkg::ctrl_latch_off, 32'h0000_0006, ok);
    rd(dpio_pkg::ctrl_pin_levels_off, z, ok);
    wr(dpio_pkg::ctrl_dir_off, 32'h0000_0007, ok);
    {host_ctrl_en, host_ctrl} <= 4'hF;
    {input_word_pending, output_word_pending, input_overrun_set} <= 3'h7;
    @(posedge aclk);
    input_overrun_set <= 1'b0;
    wr(dpio_pkg::ctrl_dir_off, 32'h0000_0037, ok);
    rd(dpio_pkg::ctrl_dir_off, 32'h0000_00F7, ok);
    chk(32'(slave_interface_active), 32'h0000_0001);
    wr(dpio_pkg::ctrl_dir_off, 32'h0000_0017, ok);
    rd(dpio_pkg::ctrl_dir_off, 32'h0000_00D7, ok);
    wr(dpio_pkg::wide_latch_off, 32'h0000_00A0, ok);
    wr(dpio_pkg::wide_dir_off, 32'h0000_00E0, ok);
    settle;
    chk(32'(wide_pin_oe), z);
    rd(dpio_pkg::wide_pin_levels_off, 32'h0000_0030, ok);
    @(posedge aclk);
    {host_wide_en, host_ctrl} <= 4'h2;
    settle;
    chk(32'(wide_pin_oe), 32'h0000_000F);
    chk(32'(wide_pin_out), 32'h0000_000A);
    @(posedge aclk);
    {host_wide_en, host_ctrl} <= 4'hF;
    {pwm_channel_b_out, pwm_channel_c_out, pwm_channel_d_out} <= 3'h2;
    settle;
    chk(32'(wide_pin_oe), z);
    wr(dpio_pkg::pwm_config_off, 32'h0000_00C1, ok);
    chk(32'(slave_interface_active), z);
    wr(dpio_pkg::wide_dir_off, z, ok);
    settle;
    chk(32'(wide_pin_out), 32'h0000_0004);
    @(posedge aclk);
    pwm_shutdown <= 1'b1;
    settle;
    chk(32'(wide_pin_oe), 32'h0000_0001);
    wr(dpio_pkg::pwm_config_off, 32'h0000_00C0, ok);
    settle;
    chk(32'(wide_pin_oe), 32'h0000_000F);
    rd(8'h20, z, er);
    wr(8'h24, 32'h0000_0001, er);
    wrap_up;
  end
endmodule : dual_port_io_with_slave_override_tb_top
`default_nettype wire
